/* rtl/cusi_regs.vh */
// Purpose: Constants for the card update status indicator
// Assumes: 20 MHz system clock
// Notes:   Times are kept in their own unit, cycle counts derived in RTL
`ifndef CUSI_REGS_VH
`define CUSI_REGS_VH

// ==========================================
// Timing
`define CUSI_CLK_HZ        20000000
`define CUSI_UPD_LIMIT_S   300
`define CUSI_WINDOW_S      5
`define CUSI_FLASH_HALF_MS 500
`define CUSI_FAST_HALF_MS  100

// ==========================================
// LED colour codes
`define CUSI_LED_OFF    3'h0
`define CUSI_LED_BLUE   3'h1
`define CUSI_LED_YELLOW 3'h2
`define CUSI_LED_WHITE  3'h3

// ==========================================
// Update trigger and error numbers
`define CUSI_TRIG_VALUE 8'h1b
`define CUSI_ERR_NONE   5'h00
`define CUSI_ERR_EEPROM 5'h01
`define CUSI_ERR_NOIMG  5'h02
`define CUSI_ERR_SAME   5'h03
`define CUSI_ERR_BADIMG 5'h04
`define CUSI_ERR_DUPF   5'h05
`define CUSI_ERR_RAM    5'h06
`define CUSI_ERR_AFTCS  5'h07
`define CUSI_ERR_VPP    5'h08
`define CUSI_ERR_VPPON  5'h0e
`define CUSI_ERR_VPPOFF 5'h13
`define CUSI_ERR_ERASE  5'h10
`define CUSI_ERR_WRITE  5'h11
`define CUSI_ERR_VERIFY 5'h12
`define CUSI_ERR_PULLED 5'h17
`define CUSI_ERR_CSUM   5'h19

`endif

/* rtl/cusi_flash_code.v */
// Purpose: Repeating LED flash code sequencer for one or two pulse groups
// Assumes: tick_in is a one-cycle pulse every 500 ms
// Notes:   White 1 s, dark 1 s, pulses, [dark 1 s, pulses], dark 1 s, repeat
`timescale 1ns/100ps
`include "cusi_regs.vh"

module cusi_flash_code (
	input  wire       sys_clk_in,
	input  wire       rst_in,
	input  wire       tick_in,
	input  wire       run_in,
	input  wire [4:0] first_in,
	input  wire [4:0] second_in,
	output reg  [2:0] led_out
);

	// ==========================================
	// Sequencer
	localparam ST_WHITE = 3'h0;
	localparam ST_GAP1  = 3'h1;
	localparam ST_PULSE = 3'h2;
	localparam ST_MID   = 3'h3;
	localparam ST_GAP2  = 3'h4;

	reg [2:0] state;
	reg       half;    // Second 500 ms of a 1 s phase
	reg [4:0] count;   // Pulses left in the group
	reg       group2;  // Second group in progress

	// Each phase lasts two ticks; a pulse is one tick on, one tick off
	always @(posedge sys_clk_in) begin
		if (rst_in || !run_in) begin
			state  <= ST_WHITE;
			half   <= 1'b0;
			count  <= 5'h00;
			group2 <= 1'b0;
		end else if (tick_in) begin
			half <= ~half;
			if (half) begin
				case (state)
				ST_WHITE: state <= ST_GAP1;
				ST_GAP1: begin
					state <= ST_PULSE;
					count <= first_in;
					group2 <= 1'b0;
				end
				ST_PULSE: begin
					if (count > 5'h01) begin
						count <= count - 5'h01;
					end else if (!group2 && second_in != `CUSI_ERR_NONE) begin
						state <= ST_MID;
					end else begin
						state <= ST_GAP2;
					end
				end
				ST_MID: begin
					state  <= ST_PULSE;
					count  <= second_in;
					group2 <= 1'b1;
				end
				ST_GAP2: state <= ST_WHITE;          // Repeats forever
				default: state <= ST_WHITE;
				endcase
			end
		end
	end

	// Output colour from the phase
	always @(posedge sys_clk_in) begin
		if (rst_in || !run_in)
			led_out <= `CUSI_LED_OFF;
		else if (state == ST_WHITE)
			led_out <= `CUSI_LED_WHITE;
		else if (state == ST_PULSE && !half && !(tick_in))
			led_out <= `CUSI_LED_WHITE;
		else if (state == ST_PULSE && half && tick_in && count > 5'h01)
			led_out <= `CUSI_LED_WHITE;
		else
			led_out <= `CUSI_LED_OFF;
	end

endmodule // cusi_flash_code

/* rtl/cusi_top.v */
// Purpose: Card-based firmware update sequencing and status LED signalling
// Assumes: Update engine, card slot and menu are outside; inputs synchronous
// Notes:   Error outcomes latch until power is removed (reset)
`timescale 1ns/100ps
`include "cusi_regs.vh"

module cusi_top #(
	parameter CLK_HZ = `CUSI_CLK_HZ,
	parameter HALF_CYC = CLK_HZ / 1000 * `CUSI_FLASH_HALF_MS,
	parameter FAST_CYC = CLK_HZ / 1000 * `CUSI_FAST_HALF_MS,
	parameter WIN_TICKS = `CUSI_WINDOW_S * 2,
	parameter LIM_TICKS = `CUSI_UPD_LIMIT_S * 2
) (
	input  wire       sys_clk_in,
	input  wire       rst_in,
	input  wire       card_busy_in,
	input  wire       card_present_in,
	input  wire       first_yellow_in,
	input  wire [7:0] trig_value_in,
	input  wire       trig_confirm_in,
	input  wire       upd_done_in,
	input  wire       upd_fail_in,
	input  wire [4:0] upd_err_in,
	input  wire       csum_flag_in,
	input  wire [2:0] normal_led_in,
	output reg  [2:0] led_out,
	output reg        upd_start_out,
	output reg        upd_wait_out,
	output reg        restart_out,
	output reg        window_out
);

	// ==========================================
	// 500 ms and fast flash dividers
	reg [31:0] div_cnt;
	reg [31:0] fast_cnt;
	reg        tick;
	reg        fast_led;

	always @(posedge sys_clk_in) begin
		if (rst_in) begin
			div_cnt  <= 32'h0;
			tick     <= 1'b0;
		end else if (div_cnt == HALF_CYC - 1) begin
			div_cnt  <= 32'h0;
			tick     <= 1'b1;
		end else begin
			div_cnt  <= div_cnt + 32'h1;
			tick     <= 1'b0;
		end
	end

	// Fast flash toggle for the reinsertion window
	always @(posedge sys_clk_in) begin
		if (rst_in) begin
			fast_cnt <= 32'h0;
			fast_led <= 1'b0;
		end else if (fast_cnt == FAST_CYC - 1) begin
			fast_cnt <= 32'h0;
			fast_led <= ~fast_led;
		end else begin
			fast_cnt <= fast_cnt + 32'h1;
		end
	end

	// ==========================================
	// Sequencer
	localparam ST_IDLE   = 3'h0;
	localparam ST_WIN    = 3'h1;
	localparam ST_REINS  = 3'h2;
	localparam ST_UPDATE = 3'h3;
	localparam ST_RESTRT = 3'h4;
	localparam ST_ERROR  = 3'h5;

	reg  [2:0]  state;
	reg  [9:0]  ticks;      // 500 ms units since the window or the update began
	reg         seen_yel;   // Window opens only once per power-up
	reg  [4:0]  err_a;
	reg  [4:0]  err_b;
	wire        menu_trig = trig_confirm_in &&
	                        trig_value_in == `CUSI_TRIG_VALUE;

	// Error number mapping; codes 0x0e and 0x13 split into the pair 8 then the code
	function [9:0] cusi_map;
		input [4:0] e;
		begin
			if (e == `CUSI_ERR_VPPON || e == `CUSI_ERR_VPPOFF)
				cusi_map = {`CUSI_ERR_VPP, e};
			else
				cusi_map = {e, `CUSI_ERR_NONE};
		end
	endfunction

	always @(posedge sys_clk_in) begin
		if (rst_in) begin
			state     <= ST_IDLE;
			ticks     <= 10'h0;
			seen_yel  <= 1'b0;
			err_a     <= `CUSI_ERR_NONE;
			err_b     <= `CUSI_ERR_NONE;
			upd_start_out <= 1'b0;
			restart_out   <= 1'b0;
		end else begin
			upd_start_out <= 1'b0;
			restart_out   <= 1'b0;
			if (tick)
				ticks <= ticks + 10'h1;
			case (state)
			ST_IDLE: begin
				ticks <= 10'h0;
				if (csum_flag_in) begin
					state <= ST_ERROR;
					err_a <= `CUSI_ERR_AFTCS;
				end else if (menu_trig) begin
					state <= ST_UPDATE;
					upd_start_out <= 1'b1;
				end else if (first_yellow_in && !seen_yel) begin
					seen_yel <= 1'b1;
					state <= ST_WIN;
				end
			end
			ST_WIN: begin
				if (ticks >= WIN_TICKS)
					state <= ST_IDLE;
				else if (!card_present_in)
					state <= ST_REINS;
			end
			ST_REINS: begin
				if (ticks >= WIN_TICKS) begin
					state <= ST_IDLE;
				end else if (card_present_in) begin
					state <= ST_UPDATE;
					ticks <= 10'h0;
					upd_start_out <= 1'b1;
				end
			end
			ST_UPDATE: begin
				if (!card_present_in) begin
					state <= ST_ERROR;
					err_a <= `CUSI_ERR_PULLED;
				end else if (upd_fail_in) begin
					state <= ST_ERROR;
					{err_a, err_b} <= cusi_map(upd_err_in);
				end else if (upd_done_in) begin
					state <= ST_RESTRT;
				end else if (ticks >= LIM_TICKS) begin
					state <= ST_RESTRT;              // Bound
				end
			end
			ST_RESTRT: begin
				restart_out <= 1'b1;
				state <= ST_IDLE;
				ticks <= 10'h0;
			end
			ST_ERROR: state <= ST_ERROR;             // Held until power-off
			default: state <= ST_IDLE;
			endcase
		end
	end

	// Waiting and window indications
	always @(posedge sys_clk_in) begin
		if (rst_in) begin
			upd_wait_out <= 1'b0;
			window_out   <= 1'b0;
		end else begin
			upd_wait_out <= (state == ST_UPDATE);
			window_out   <= (state == ST_WIN) || (state == ST_REINS);
		end
	end

	// ==========================================
	// Flash code sequencer
	wire [2:0] code_led;

	cusi_flash_code u_code (
		.sys_clk_in (sys_clk_in),
		.rst_in     (rst_in),
		.tick_in    (tick),
		.run_in     (state == ST_ERROR),
		.first_in   (err_a),
		.second_in  (err_b),
		.led_out    (code_led)
	);

	// LED priority: error code, card access, window flash, normal
	always @(posedge sys_clk_in) begin
		if (rst_in)
			led_out <= `CUSI_LED_OFF;
		else if (state == ST_ERROR)
			led_out <= code_led;
		else if (card_busy_in)
			led_out <= `CUSI_LED_BLUE;
		else if (state == ST_WIN || state == ST_REINS)
			led_out <= fast_led ? `CUSI_LED_YELLOW : `CUSI_LED_OFF;
		else
			led_out <= normal_led_in;
	end

endmodule // cusi_top

/* tb/cusi_top_assertions.sv */
// Purpose: Checker for the card update status indicator
// Assumes: One clock, synchronous active-high reset
// Notes:   Bounds allow one tick of phase slack
`timescale 1ns/100ps
module cusi_checker #(
	parameter HALF_CYC  = 4,
	parameter WIN_TICKS = 10,
	parameter LIM_TICKS = 600
) (
	input wire       sys_clk_in,
	input wire       rst_in,
	input wire       card_busy_in,
	input wire       card_present_in,
	input wire       first_yellow_in,
	input wire [7:0] trig_value_in,
	input wire       trig_confirm_in,
	input wire       upd_done_in,
	input wire       upd_fail_in,
	input wire [4:0] upd_err_in,
	input wire       csum_flag_in,
	input wire [2:0] normal_led_in,
	input wire [2:0] led_out,
	input wire       upd_start_out,
	input wire       upd_wait_out,
	input wire       restart_out,
	input wire       window_out
);
	int win_n;
	int wait_n;
	// =====
	// Cycles the window and the wait have stood
	always @(posedge sys_clk_in) begin
		win_n <= (rst_in || !window_out) ? 0 : win_n + 1;
		wait_n <= (rst_in || !upd_wait_out) ? 0 : wait_n + 1;
	end
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	sequence s_done; upd_wait_out && upd_done_in; endsequence
	sequence s_restart; ##[1:3] restart_out ##1 !upd_wait_out; endsequence
	a_blue_access: assert property (card_busy_in && $past(card_busy_in)
		&& !window_out |-> led_out == 3'h1) else $error("no blue in access");
	a_trig_start: assert property (trig_confirm_in && trig_value_in == 8'h1b
		&& !upd_wait_out |-> ##[1:2] upd_start_out) else $error("no start");
	a_bad_value: assert property (trig_confirm_in && trig_value_in != 8'h1b
		&& !window_out |=> !upd_start_out) else $error("wrong start");
	a_start_wait: assert property (upd_start_out |=> upd_wait_out)
		else $error("no wait after start");
	a_start_pulse: assert property (upd_start_out |=> !upd_start_out)
		else $error("start too long");
	a_wait_bound: assert property (wait_n <= (LIM_TICKS + 1) * HALF_CYC + 3)
		else $error("update too long");
	a_done_restart: assert property (s_done |-> s_restart)
		else $error("no restart after done");
	a_restart_pulse: assert property (restart_out |=> !restart_out)
		else $error("restart too long");
	a_win_bound: assert property (win_n <= (WIN_TICKS + 1) * HALF_CYC + 2)
		else $error("window too long");
	a_fail_white: assert property (upd_wait_out && upd_fail_in
		|-> ##[1:4] led_out == 3'h3) else $error("no flash code");
endmodule // cusi_checker
bind cusi_top cusi_checker #(.HALF_CYC(HALF_CYC), .WIN_TICKS(WIN_TICKS),
	.LIM_TICKS(LIM_TICKS)) cusi_checker_inst (.*);

/* tb/cusi_card_model.sv */
// Purpose: Memory card seated in the slot
// Assumes: Removal and access are requested by the bench
// Notes:   Access only while seated
`timescale 1ns/100ps
module cusi_card_model (
	input  wire sys_clk_in,
	input  wire pull_in,
	input  wire access_in,
	output reg  present_out = 1'b1,
	output reg  busy_out = 1'b0
);
	// Seat and access follow the request one edge later
	always @(posedge sys_clk_in) begin
		present_out <= !pull_in;
		busy_out <= !pull_in && access_in;
	end
endmodule // cusi_card_model

/* tb/tb.sv */
// Purpose: Scenario bench for the card update status indicator
// Assumes: Half second shortened to 4 cycles
// Notes:   Flash codes are counted from white runs
`timescale 1ns/100ps
module tb;
	reg        clk = 0, rst = 1, yel = 0, conf = 0, done = 0, fail = 0;
	reg        pull = 0, acc = 0, csf = 0;
	reg  [7:0] val = 8'h00;
	reg  [4:0] err = 5'h00;
	wire       cp, cb, st, wt, rs, win;
	wire [2:0] led;
	wire [2:0] mon = {win, rs, st};
	integer    n_fail = 0, compares = 0;
	cusi_card_model cusi_card_model_inst (.sys_clk_in(clk), .pull_in(pull),
		.access_in(acc), .present_out(cp), .busy_out(cb));
	cusi_top #(.HALF_CYC(4), .FAST_CYC(2), .WIN_TICKS(4), .LIM_TICKS(6))
	cusi_top_inst (.sys_clk_in(clk), .rst_in(rst), .card_busy_in(cb),
		.card_present_in(cp), .first_yellow_in(yel), .trig_value_in(val),
		.trig_confirm_in(conf), .upd_done_in(done), .upd_fail_in(fail),
		.upd_err_in(err), .csum_flag_in(csf), .normal_led_in(3'h2),
		.led_out(led), .upd_start_out(st), .upd_wait_out(wt),
		.restart_out(rs), .window_out(win));
	// =====
	// Clock, watchdog and helpers
	initial forever #25 clk = !clk;
	initial begin
		#5000000;
		n_fail = n_fail + 1;
		wrap_up;
	end
	task wrap_up; begin
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	end endtask
	task chk(input [31:0] got, input [31:0] exp); begin
		compares = compares + 1;
		if (got !== exp) begin
			n_fail = n_fail + 1;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	end endtask
	task till(input integer s, input integer w); integer i; begin
		i = 0;
		#1;
		while (mon[s] !== 1'b1 && i < w) begin
			@(posedge clk);
			#1 i = i + 1;
		end
		chk(mon[s], 1);
		if (mon[s] !== 1'b1) wrap_up;
	end endtask
	task do_rst; begin
		@(posedge clk); rst <= 1; pull <= 0;
		repeat (4) @(posedge clk);
		rst <= 0;
	end endtask
	task go(input [7:0] v); begin
		@(posedge clk); val <= v; conf <= 1;
		@(posedge clk); conf <= 0;
	end endtask
	task pulse_done; begin
		@(posedge clk); done <= 1;
		@(posedge clk); done <= 0;
	end endtask
	// =====
	// Scenarios
	task t_blue; begin
		@(posedge clk); acc <= 1;
		repeat (3) @(posedge clk);
		#1 chk(led, 3'h1);
		@(posedge clk); acc <= 0;
	end endtask
	task t_menu; begin
		go(8'h1a);
		repeat (3) @(posedge clk);
		#1 chk(wt, 0);
		go(8'h1b);
		till(0, 4);
		@(posedge clk); #1 chk(wt, 1);
		pulse_done;
		till(1, 4);
		@(posedge clk); #1 chk(wt, 0);
		go(8'h1b);
		till(1, 40);
	end endtask
	task t_win(input late); integer i, ny, nd; begin
		do_rst;
		@(posedge clk); yel <= 1;
		@(posedge clk); yel <= 0;
		till(2, 4);
		if (late) begin
			ny = 0;
			nd = 0;
			// Fast flash: both yellow and dark seen while window open
			for (i = 0; i < 24; i = i + 1) begin
				@(posedge clk);
				#1 if (win === 1'b1 && led === 3'h2) ny = ny + 1;
				if (win === 1'b1 && led === 3'h0) nd = nd + 1;
			end
			chk({ny != 0, nd != 0}, 3);
			chk(win, 0);
		end
		@(posedge clk); pull <= 1;
		repeat (2) @(posedge clk); pull <= 0;
		if (late) begin
			repeat (4) @(posedge clk);
			#1 chk(wt, 0);
		end else begin
			till(0, 8);
			pulse_done;
			till(1, 4);
		end
	end endtask
	task t_flash(input [4:0] e); integer i, run, cnt, ph, n; begin
		n = (e == 5'h0e || e == 5'h13) ? e + 8 : e;
		do_rst;
		if (e == 5'h07) csf <= 1;
		else begin
			go(8'h1b);
			till(0, 4);
			@(posedge clk);
			if (e == 5'h17) pull <= 1;
			else begin fail <= 1; err <= e; end
		end
		@(posedge clk); fail <= 0;
		csf <= 0;
		run = 0; cnt = 0; ph = 0;
		for (i = 0; i < 900 && ph < 2; i = i + 1) begin
			@(posedge clk); #1
			if (led === 3'h3) run = run + 1;
			else begin
				if (run > 5) ph = ph + 1;
				else if (run > 2 && ph == 1) cnt = cnt + 1;
				run = 0;
			end
		end
		chk(ph, 2);
		chk(cnt, n);
	end endtask
	// =====
	// Main sequence
	initial begin
		do_rst;
		t_blue;
		t_menu;
		t_win(0);
		t_win(1);
		t_flash(5'h01);
		t_flash(5'h02);
		t_flash(5'h04);
		t_flash(5'h03);
		t_flash(5'h05);
		t_flash(5'h06);
		t_flash(5'h07);
		t_flash(5'h0e);
		t_flash(5'h13);
		t_flash(5'h10);
		t_flash(5'h11);
		t_flash(5'h12);
		t_flash(5'h17);
		t_flash(5'h19);
		wrap_up;
	end
endmodule // tb
